// [pfb_pkg.sv]
// constants, state encodings and register map of the fault and brown-out sequencer
// assumes a single 20 MHz core clock and synchronous comparator flags
package pfb_pkg;

   // timing base
   localparam int unsigned CLK_KHZ      = 20000;
   localparam int unsigned BO_BLANK_MS  = 50;
   localparam int unsigned BO_WINDOW_MS = 50;
   localparam int unsigned TP_BLANK_US  = 30;
   localparam int unsigned SETTLE_US    = 1;
   localparam int unsigned WD_SHORT_US  = 20;
   localparam int unsigned WD_LONG_US   = 200;
   localparam int unsigned US_PER_MS    = 1000;

   // timer counters
   localparam int TMR_W = 20;
   localparam logic [TMR_W-1:0] TMR_ONE       = 20'h00001;
   localparam int unsigned      BO_BLANK_CYC  = CLK_KHZ * BO_BLANK_MS;
   localparam int unsigned      BO_WINDOW_CYC = CLK_KHZ * BO_WINDOW_MS;
   localparam logic [TMR_W-1:0] TP_BLANK_LEN  = TMR_W'(CLK_KHZ * TP_BLANK_US / US_PER_MS);
   localparam logic [TMR_W-1:0] WD_SHORT_LEN  = TMR_W'(CLK_KHZ * WD_SHORT_US / US_PER_MS);
   localparam logic [TMR_W-1:0] WD_LONG_LEN   = TMR_W'(CLK_KHZ * WD_LONG_US / US_PER_MS);

   // settle delay counter
   localparam int SET_W = 8;
   localparam logic [SET_W-1:0] SETTLE_LEN = SET_W'(CLK_KHZ * SETTLE_US / US_PER_MS);
   localparam logic [SET_W-1:0] SET_ONE    = 8'h01;

   // bus
   localparam int ADEC_W = 8;
   localparam logic [ADEC_W-1:0] REG_STATUS = 8'h00;
   localparam logic [ADEC_W-1:0] REG_CTRL   = 8'h04;
   localparam logic [ADEC_W-1:0] REG_EVENTS = 8'h08;
   localparam logic [1:0]        HTRANS_NONSEQ = 2'h2;
   localparam logic              HRESP_OKAY    = 1'h0;
   localparam logic [31:0]       CTRL_RESET    = 32'h00000000;

   // status bits
   localparam int ST_BROWNOUT = 0;
   localparam int ST_OFF      = 1;
   localparam int ST_OVERTEMP = 2;
   localparam int ST_TP_OPEN  = 3;
   localparam int ST_LOCKOUT  = 4;
   localparam int ST_READY    = 5;
   localparam int ST_BO_LO    = 8;
   localparam int ST_BO_HI    = 9;

   // control bits
   localparam int CTRL_LATCHOFF = 0;

   // sticky event bits
   localparam int EV_W        = 4;
   localparam int EV_BROWNOUT = 0;
   localparam int EV_TP_OPEN  = 1;
   localparam int EV_OVERTEMP = 2;
   localparam int EV_WDOG     = 3;

   typedef enum logic [1:0] {
      PFB_BO_FAULT   = 2'b00,
      PFB_BO_MONITOR = 2'b01,
      PFB_BO_BLANK   = 2'b10,
      PFB_BO_WINDOW  = 2'b11
   } pfb_bo_state_t;

endpackage

// [pfb_timer.sv]
// one-shot down counter with a one-cycle done pulse
// assumes length is at least one; start wins over abort
module pfb_timer
   import pfb_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // control
   input  wire logic             start,
   input  wire logic             abort,
   input  wire logic [TMR_W-1:0] length,
   // status
   output logic                  busy_r,
   output logic                  done_r
);

   logic [TMR_W-1:0] cnt_r;
   wire              last_w = busy_r && (cnt_r == TMR_ONE);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= last_w && !start && !abort;
         if (start) begin
            cnt_r  <= length;
            busy_r <= 1'b1;
         end else if (abort || last_w) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
         end else if (busy_r) begin
            cnt_r <= cnt_r - TMR_ONE;
         end
      end
   end

endmodule

// [pfb_ahb_if.sv]
// zero-wait AHB-Lite slave front end: phase tracking and read data register
// assumes single word transfers; read data is chosen by the parent from haddr
module pfb_ahb_if
   import pfb_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // address phase
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic              hready,
   input  wire logic [31:0]       rd_word,
   // answer
   output logic [31:0]            hrdata_r,
   output logic                   hreadyout_r,
   output logic                   hresp_r,
   // write strobe in the data phase
   output logic                   wr_pend_r,
   output logic [ADEC_W-1:0]      wr_addr_r
);

   wire take_w = hsel && htrans[1] && hready;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hrdata_r    <= '0;
         hreadyout_r <= 1'b1;
         hresp_r     <= HRESP_OKAY;
         wr_pend_r   <= 1'b0;
         wr_addr_r   <= '0;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r     <= HRESP_OKAY;
         wr_pend_r   <= take_w && hwrite;
         if (take_w) begin
            wr_addr_r <= haddr[ADEC_W-1:0];
         end
         if (take_w && !hwrite) begin
            hrdata_r <= rd_word;
         end
      end
   end

endmodule

// [pfb_sequencer.sv]
// fault, brown-out and OFF-mode sequencer of a two-phase interleaved PFC stage
// assumes comparator flags synchronous to core_clk; rst follows supply lockout
//
// Added by the designer: the AHB-Lite register port and the register addresses.
module pfb_sequencer
   import pfb_pkg::*;
#(
   parameter int unsigned BO_BLANK_CYCLES  = BO_BLANK_CYC,
   parameter int unsigned BO_WINDOW_CYCLES = BO_WINDOW_CYC
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // line sensing
   input  wire logic        line_low_cmp,
   input  wire logic        line_amp_high,
   // supply and protection comparators
   input  wire logic        vcc_above_on,
   input  wire logic        vcc_above_off,
   input  wire logic        undervoltage_fault,
   input  wire logic        latchoff_in,
   input  wire logic        temp_above_hi,
   input  wire logic        temp_below_lo,
   input  wire logic        timing_current_low,
   // switching requests from the pwm core
   input  wire logic [1:0]  gate_req,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // power stage and analog controls
   output logic [1:0]       gate_drv_r,
   output logic             level_hold_en_r,
   output logic             amp_attach_r,
   output logic             hysteresis_sink_r,
   output logic             pin_clamp_r,
   output logic             loop_control_node_r,
   output logic             ontime_processing_out_r,
   output logic             stage_ready_out_r,
   output logic             watchdog_kick_r,
   // fault status
   output logic             brownout_fault_r,
   output logic             overtemp_fault_r,
   output logic             timing_pin_open_r,
   output logic             supply_lockout_r,
   output logic             off_mode_r
);

   function automatic logic reg_hit(input logic [31:0] a, input logic [ADEC_W-1:0] off);
      reg_hit = (a[ADEC_W-1:0] == off);
   endfunction

   pfb_bo_state_t   bo_r;
   pfb_bo_state_t   bo_nxt;
   logic            bo_start;
   logic            bo_busy;
   logic            bo_done;
   logic            bo_shut_r;
   logic [SET_W-1:0] settle_cnt_r;
   logic            tp_busy;
   logic            tp_done;
   logic            wd_busy;
   logic            wd_done;
   logic [31:0]     ctrl_r;
   logic [EV_W-1:0] events_r;
   logic [EV_W-1:0] ev_set;
   logic            wr_pend;
   logic [ADEC_W-1:0] wr_addr;

   // supply lockout with hysteresis between the two comparator levels
   wire lockout_nxt = !vcc_above_off || (supply_lockout_r && !vcc_above_on);

   // overtemp latch: set above the upper level, release below the lower
   wire ot_nxt = temp_above_hi || (overtemp_fault_r && !temp_below_lo);

   // timing pin: fault only after a full blanking interval of low current
   wire tp_start = timing_current_low && !tp_busy && !timing_pin_open_r;
   wire tp_nxt   = tp_done || (timing_pin_open_r && !supply_lockout_r);

   // brown-out sequence
   wire [TMR_W-1:0] bo_len = (bo_r == PFB_BO_MONITOR) ?
                             TMR_W'(BO_BLANK_CYCLES) : TMR_W'(BO_WINDOW_CYCLES);
   wire bo_fault_w = (bo_r == PFB_BO_FAULT);

   always_comb begin
      bo_nxt   = bo_r;
      bo_start = 1'b0;
      case (bo_r)
         PFB_BO_FAULT: begin
            // amplifier detached, so leaving needs the pin back above threshold
            if (!line_low_cmp && !supply_lockout_r) begin
               bo_nxt = PFB_BO_MONITOR;
            end
         end
         PFB_BO_MONITOR: begin
            if (line_low_cmp) begin
               bo_nxt   = PFB_BO_BLANK;
               bo_start = 1'b1;
            end
         end
         PFB_BO_BLANK: begin
            // nothing is judged here, which hides short mains gaps
            if (bo_done) begin
               bo_nxt   = PFB_BO_WINDOW;
               bo_start = 1'b1;
            end
         end
         PFB_BO_WINDOW: begin
            if (line_amp_high) begin
               bo_nxt = PFB_BO_FAULT;
            end else if (bo_done) begin
               bo_nxt = PFB_BO_MONITOR;
            end
         end
         default: begin
            bo_nxt = PFB_BO_FAULT;
         end
      endcase
      if (supply_lockout_r) begin
         bo_nxt   = PFB_BO_FAULT;
         bo_start = 1'b0;
      end
   end

   // one timer serves blank and window; it is reloaded on each entry
   pfb_timer u_bo_tmr (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (bo_start),
      .abort    (bo_nxt == PFB_BO_FAULT || bo_nxt == PFB_BO_MONITOR),
      .length   (bo_len),
      .busy_r   (bo_busy),
      .done_r   (bo_done)
   );

   // any break in the low current restarts the blanking
   pfb_timer u_tp_tmr (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (tp_start),
      .abort    (!timing_current_low),
      .length   (TP_BLANK_LEN),
      .busy_r   (tp_busy),
      .done_r   (tp_done)
   );

   // settle: amp detach and sink go first, shutdown follows SETTLE_LEN later
   wire settle_end = (settle_cnt_r == SETTLE_LEN);
   wire shut_nxt   = bo_fault_w && (bo_shut_r || settle_end);
   wire [SET_W-1:0] settle_nxt = (bo_fault_w && !bo_shut_r) ?
                                 settle_cnt_r + SET_ONE : '0;

   // off mode collects every shutdown source
   wire off_nxt = bo_shut_r | undervoltage_fault | latchoff_in | overtemp_fault_r |
                  timing_pin_open_r | supply_lockout_r | ctrl_r[CTRL_LATCHOFF];

   // restart watchdog: short first period on leaving OFF, long otherwise
   wire leave_off = off_mode_r && !off_nxt;
   wire wd_start  = !off_nxt && (leave_off || (|gate_req) || wd_done);
   wire [TMR_W-1:0] wd_len = leave_off ? WD_SHORT_LEN : WD_LONG_LEN;

   pfb_timer u_wd_tmr (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (wd_start),
      .abort    (off_nxt),
      .length   (wd_len),
      .busy_r   (wd_busy),
      .done_r   (wd_done)
   );

   // sink on during brown-out or OFF, but never before supply-on
   // keyed on the state, so it lands one edge after the fault flag
   wire sink_nxt = !supply_lockout_r && (bo_fault_w || off_nxt);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bo_r              <= PFB_BO_FAULT;
         bo_shut_r         <= 1'b1;
         settle_cnt_r      <= '0;
         supply_lockout_r  <= 1'b1;
         overtemp_fault_r  <= 1'b0;
         timing_pin_open_r <= 1'b0;
         off_mode_r        <= 1'b1;
      end else begin
         bo_r              <= bo_nxt;
         bo_shut_r         <= shut_nxt;
         settle_cnt_r      <= settle_nxt;
         supply_lockout_r  <= lockout_nxt;
         overtemp_fault_r  <= ot_nxt;
         timing_pin_open_r <= tp_nxt;
         off_mode_r        <= off_nxt;
      end
   end

   // gate drives held sinking whenever the stage is off
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_drv
         always_ff @(posedge core_clk) begin
            if (rst) begin
               gate_drv_r[g] <= 1'b0;
            end else begin
               gate_drv_r[g] <= gate_req[g] && !off_nxt;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (rst) begin
         level_hold_en_r         <= 1'b0;
         amp_attach_r            <= 1'b0;
         hysteresis_sink_r       <= 1'b0;
         pin_clamp_r             <= 1'b1;
         loop_control_node_r     <= 1'b1;
         ontime_processing_out_r <= 1'b1;
         stage_ready_out_r       <= 1'b0;
         watchdog_kick_r         <= 1'b0;
         brownout_fault_r        <= 1'b1;
      end else begin
         level_hold_en_r         <= bo_nxt == PFB_BO_BLANK || bo_nxt == PFB_BO_WINDOW;
         amp_attach_r            <= bo_nxt != PFB_BO_FAULT;
         hysteresis_sink_r       <= sink_nxt;
         pin_clamp_r             <= supply_lockout_r;
         loop_control_node_r     <= off_nxt;
         ontime_processing_out_r <= off_nxt;
         stage_ready_out_r       <= !off_nxt;
         watchdog_kick_r         <= wd_done;
         brownout_fault_r        <= bo_nxt == PFB_BO_FAULT;
      end
   end

   // register file: control, status and sticky events
   assign ev_set[EV_BROWNOUT] = bo_nxt == PFB_BO_FAULT && !bo_fault_w;
   assign ev_set[EV_TP_OPEN]  = tp_done;
   assign ev_set[EV_OVERTEMP] = ot_nxt && !overtemp_fault_r;
   assign ev_set[EV_WDOG]     = wd_done;

   wire [31:0] status_w = {22'h000000, bo_r, 2'h0, stage_ready_out_r, supply_lockout_r,
                           timing_pin_open_r, overtemp_fault_r, off_mode_r, brownout_fault_r};
   wire [31:0] rd_word  = reg_hit(haddr, REG_STATUS) ? status_w :
                          reg_hit(haddr, REG_CTRL)   ? ctrl_r :
                          reg_hit(haddr, REG_EVENTS) ? {28'h0000000, events_r} : '0;
   wire wr_ctrl = wr_pend && wr_addr == REG_CTRL;
   wire wr_ev   = wr_pend && wr_addr == REG_EVENTS;
   // write one to clear; a same-cycle event keeps its bit
   wire [EV_W-1:0] ev_nxt = (events_r & ~(wr_ev ? hwdata[EV_W-1:0] : '0)) | ev_set;

   pfb_ahb_if u_bus (
      .core_clk    (core_clk),
      .rst         (rst),
      .hsel        (hsel),
      .haddr       (haddr),
      .htrans      (htrans),
      .hwrite      (hwrite),
      .hready      (hready),
      .rd_word     (rd_word),
      .hrdata_r    (hrdata),
      .hreadyout_r (hreadyout),
      .hresp_r     (hresp),
      .wr_pend_r   (wr_pend),
      .wr_addr_r   (wr_addr)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_r   <= CTRL_RESET;
         events_r <= '0;
      end else begin
         events_r <= ev_nxt;
         if (wr_ctrl) begin
            ctrl_r <= {31'h00000000, hwdata[CTRL_LATCHOFF]};
         end
      end
   end

   // checks
   gate_off_low_a: assert property (@(posedge core_clk) disable iff (rst)
      off_mode_r |-> gate_drv_r == 2'b00)
      else $error("gate drive high in off mode");
   // ready trails bo_shut_r by one edge, just as off_mode_r does
   ready_off_a: assert property (@(posedge core_clk) disable iff (rst)
      stage_ready_out_r |-> !off_mode_r && !$past(bo_shut_r))
      else $error("ready high while off");
   blank_no_fault_a: assert property (@(posedge core_clk) disable iff (rst)
      bo_r == PFB_BO_BLANK && !supply_lockout_r |=> !brownout_fault_r)
      else $error("fault raised during blanking");
   window_fault_a: assert property (@(posedge core_clk) disable iff (rst)
      bo_r == PFB_BO_WINDOW && line_amp_high |=> brownout_fault_r && !amp_attach_r)
      else $error("window fault missed");
   settle_first_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(brownout_fault_r) |-> !bo_shut_r ##1 !bo_shut_r)
      else $error("shutdown without settle delay");
   sink_fault_a: assert property (@(posedge core_clk) disable iff (rst)
      brownout_fault_r && !supply_lockout_r && $stable(supply_lockout_r) |=> hysteresis_sink_r)
      else $error("sink off during brown-out");
   tp_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      timing_pin_open_r && !supply_lockout_r |=> timing_pin_open_r)
      else $error("timing latch cleared outside lockout");
   overtemp_hyst_a: assert property (@(posedge core_clk) disable iff (rst)
      overtemp_fault_r && !temp_below_lo |=> overtemp_fault_r)
      else $error("overtemp cleared above lower level");
   lockout_hyst_a: assert property (@(posedge core_clk) disable iff (rst)
      !supply_lockout_r && vcc_above_off |=> !supply_lockout_r)
      else $error("lockout without low supply");
   wd_short_a: assert property (@(posedge core_clk) disable iff (rst)
      off_mode_r && !off_nxt |=> wd_busy)
      else $error("restart watchdog not armed");
   bo_timer_run_a: assert property (@(posedge core_clk) disable iff (rst)
      (bo_r == PFB_BO_BLANK || bo_r == PFB_BO_WINDOW) |-> bo_busy || bo_done)
      else $error("brown-out timer idle while timing");

endmodule

// [pfb_analog_model.sv]
// analog side model: supply, line-sense and die temperature comparators
// assumes the bench sets supply millivolts, line condition and temperature
module pfb_analog_model
#(
   parameter int VCC_ON_MV  = 12000,
   parameter int VCC_HYS_MV = 2000,
   parameter int T_HI_C     = 140,
   parameter int T_LO_C     = 80
) (
   // conditions set by the bench
   input  wire logic [1:0]  line_state,
   input  wire logic [15:0] vcc_mv,
   input  wire logic [7:0]  temp_c,
   // sense pin switch from the sequencer
   input  wire logic        amp_attach,
   // comparator flags
   output logic             line_low_cmp,
   output logic             line_amp_high,
   output logic             vcc_above_on,
   output logic             vcc_above_off,
   output logic             temp_above_hi,
   output logic             temp_below_lo
);
   timeunit 1ns;
   timeprecision 1ns;
   // line_state: 0 healthy, 1 sagging, 2 lost
   assign line_low_cmp  = (line_state != 2'h0);
   // once detached the amplifier cannot hold the pin, so it reads high until the line is back
   assign line_amp_high = (line_state == 2'h2) | (~amp_attach & (line_state != 2'h0));
   assign vcc_above_on  = (vcc_mv >= 16'(VCC_ON_MV));
   assign vcc_above_off = (vcc_mv >= 16'(VCC_ON_MV - VCC_HYS_MV));
   assign temp_above_hi = (temp_c > 8'(T_HI_C));
   assign temp_below_lo = (temp_c < 8'(T_LO_C));
endmodule

// [tb_top.sv]
// self-checking bench of the fault and brown-out sequencer
// assumes a 20 MHz core clock and the analog model on the comparator side
module tb_top
   import pfb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // brown-out timers shortened so the run stays short
   localparam int BLK = 50;
   localparam int WIN = 50;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  line_state = 2'h0;
   logic [15:0] vcc_mv = 16'h0000;
   logic [7:0]  temp_c = 8'h19;
   logic        undervoltage_fault = 1'b0;
   logic        latchoff_in = 1'b0;
   logic        timing_current_low = 1'b0;
   logic [1:0]  gate_req = 2'h0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] rd;
   int          mismatches = 0;
   int          cmp_count = 0;
   int          c;
   wire logic        line_low_cmp, line_amp_high, vcc_above_on, vcc_above_off;
   wire logic        temp_above_hi, temp_below_lo, hreadyout, hresp;
   wire logic [31:0] hrdata;
   wire logic [1:0]  gate_drv_r;
   wire logic        level_hold_en_r, amp_attach_r, hysteresis_sink_r, pin_clamp_r;
   wire logic        loop_control_node_r, ontime_processing_out_r, stage_ready_out_r;
   wire logic        watchdog_kick_r, brownout_fault_r, overtemp_fault_r;
   wire logic        timing_pin_open_r, supply_lockout_r, off_mode_r;
   wire logic [11:0] snap = {brownout_fault_r, supply_lockout_r, off_mode_r, gate_drv_r,
      stage_ready_out_r, loop_control_node_r, ontime_processing_out_r, pin_clamp_r,
      hysteresis_sink_r, overtemp_fault_r, timing_pin_open_r};

   always #25 core_clk = ~core_clk;

   pfb_analog_model ana (.line_state(line_state), .vcc_mv(vcc_mv), .temp_c(temp_c),
      .amp_attach(amp_attach_r), .line_low_cmp(line_low_cmp), .line_amp_high(line_amp_high),
      .vcc_above_on(vcc_above_on), .vcc_above_off(vcc_above_off),
      .temp_above_hi(temp_above_hi), .temp_below_lo(temp_below_lo));

   pfb_sequencer #(.BO_BLANK_CYCLES(BLK), .BO_WINDOW_CYCLES(WIN)) uut (
      .core_clk(core_clk), .rst(rst), .line_low_cmp(line_low_cmp),
      .line_amp_high(line_amp_high), .vcc_above_on(vcc_above_on),
      .vcc_above_off(vcc_above_off), .undervoltage_fault(undervoltage_fault),
      .latchoff_in(latchoff_in), .temp_above_hi(temp_above_hi),
      .temp_below_lo(temp_below_lo), .timing_current_low(timing_current_low),
      .gate_req(gate_req), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .gate_drv_r(gate_drv_r),
      .level_hold_en_r(level_hold_en_r), .amp_attach_r(amp_attach_r),
      .hysteresis_sink_r(hysteresis_sink_r), .pin_clamp_r(pin_clamp_r),
      .loop_control_node_r(loop_control_node_r),
      .ontime_processing_out_r(ontime_processing_out_r),
      .stage_ready_out_r(stage_ready_out_r), .watchdog_kick_r(watchdog_kick_r),
      .brownout_fault_r(brownout_fault_r), .overtemp_fault_r(overtemp_fault_r),
      .timing_pin_open_r(timing_pin_open_r), .supply_lockout_r(supply_lockout_r),
      .off_mode_r(off_mode_r));

   task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic ed(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // single word transfer; the slave's own hreadyout is the bus ready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= 3'h2;
      ed(1);
      while (hreadyout !== 1'b1) ed(1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      ed(1);
      while (hreadyout !== 1'b1) ed(1);
      q = hrdata;
      ck("hresp", hresp, HRESP_OKAY);
   endtask

   function automatic logic sg(input int w);
      case (w)
         0: return brownout_fault_r;
         1: return off_mode_r;
         2: return watchdog_kick_r;
         3: return ~off_mode_r;
         default: return timing_pin_open_r;
      endcase
   endfunction

   // counts edges until the chosen flag is high, giving up at lim
   task automatic upto(input int w, input int lim, output int n);
      n = 0;
      while (sg(w) !== 1'b1 && n < lim) begin
         ed(1);
         #1;
         n++;
      end
   endtask

   task automatic t_power();
      ed(1);
      vcc_mv <= 16'h30D4;
      #1;
      upto(3, 20, c);
      upto(2, 500, c);
      ck("wd_short", c >= int'(WD_SHORT_LEN) - 2 && c <= int'(WD_SHORT_LEN) + 4, 1'b1);
      ck("run", snap, 12'h040);
      ed(1);
      #1;
      upto(2, 4100, c);
      ck("wd_long", c >= int'(WD_LONG_LEN) - 2 && c <= int'(WD_LONG_LEN) + 4, 1'b1);
      ed(1);
      gate_req <= 2'h3;
      ed(2);
      #1;
      ck("gates", gate_drv_r, 2'h3);
      $display("power done");
   endtask

   task automatic t_dip();
      ed(1);
      line_state <= 2'h1;
      ed(2);
      #1;
      ck("hold", level_hold_en_r, 1'b1);
      ed(BLK / 2 - 2);
      line_state <= 2'h0;
      ed(BLK + WIN);
      #1;
      ck("dip", {brownout_fault_r, stage_ready_out_r}, 2'b01);
      ed(1);
      line_state <= 2'h1;
      ed(BLK + WIN + 10);
      #1;
      ck("window", {brownout_fault_r, stage_ready_out_r}, 2'b01);
      ed(1);
      line_state <= 2'h0;
      ed(BLK + WIN + 10);
      $display("dip done");
   endtask

   task automatic t_brown();
      ed(1);
      line_state <= 2'h2;
      #1;
      upto(0, BLK + WIN + 10, c);
      ck("bo_time", c >= BLK && c <= BLK + 5, 1'b1);
      ed(1);
      #1;
      ck("bo_onset", {amp_attach_r, hysteresis_sink_r, off_mode_r, stage_ready_out_r}, 4'h5);
      upto(1, 40, c);
      ck("settle", c >= int'(SETTLE_LEN) - 1 && c <= int'(SETTLE_LEN) + 3, 1'b1);
      ed(2);
      #1;
      ck("bo_off", snap, 12'hA34);
      ed(1);
      line_state <= 2'h1;
      ed(BLK);
      #1;
      ck("bo_held", brownout_fault_r, 1'b1);
      ed(1);
      line_state <= 2'h0;
      #1;
      upto(3, 20, c);
      ed(2);
      #1;
      ck("bo_exit", snap, 12'h1C0);
      $display("brownout done");
   endtask

   task automatic set_fault(input int k, input logic v);
      case (k)
         0: undervoltage_fault <= v;
         1: latchoff_in <= v;
         2: temp_c <= v ? 8'h96 : 8'h19;
         default: bus(1'b1, REG_CTRL, {31'h0, v}, rd);
      endcase
   endtask

   task automatic t_faults();
      for (int k = 0; k < 4; k++) begin
         ed(1);
         set_fault(k, 1'b1);
         #1;
         upto(1, 10, c);
         ck("off_lat", c <= 3, 1'b1);
         ed(2);
         #1;
         ck("off", {off_mode_r, gate_drv_r, stage_ready_out_r, loop_control_node_r}, 5'h11);
         if (k == 2) begin
            ed(1);
            temp_c <= 8'h64;
            ed(5);
            #1;
            ck("hyst", overtemp_fault_r, 1'b1);
         end
         ed(1);
         set_fault(k, 1'b0);
         #1;
         upto(3, 20, c);
         ck("recover", c < 20, 1'b1);
      end
      $display("faults done");
   endtask

   task automatic t_tpin();
      ed(1);
      timing_current_low <= 1'b1;
      ed(300);
      timing_current_low <= 1'b0;
      #1;
      ck("tp_blank", timing_pin_open_r, 1'b0);
      ed(1);
      timing_current_low <= 1'b1;
      #1;
      upto(4, 700, c);
      ck("tp_time", c >= int'(TP_BLANK_LEN) - 5 && c <= int'(TP_BLANK_LEN) + 10, 1'b1);
      ed(1);
      timing_current_low <= 1'b0;
      ed(10);
      #1;
      ck("tp_hold", {timing_pin_open_r, off_mode_r, hysteresis_sink_r}, 3'b111);
      ed(1);
      vcc_mv <= 16'h2AF8;
      ed(5);
      #1;
      ck("vcc_hys", {supply_lockout_r, timing_pin_open_r}, 2'b01);
      ed(1);
      vcc_mv <= 16'h2328;
      ed(5);
      #1;
      ck("lockout", {supply_lockout_r, timing_pin_open_r, pin_clamp_r, hysteresis_sink_r}, 4'hA);
      ed(1);
      vcc_mv <= 16'h2AF8;
      ed(5);
      #1;
      ck("vcc_low", supply_lockout_r, 1'b1);
      ed(1);
      vcc_mv <= 16'h30D4;
      ed(2);
      #1;
      ck("vcc_on", {supply_lockout_r, hysteresis_sink_r}, 2'b01);
      upto(3, 40, c);
      ck("tp_recover", c < 40, 1'b1);
      $display("timing pin done");
   endtask

   task automatic t_bus();
      ed(3);
      bus(1'b0, REG_STATUS, 32'h0, rd);
      ck("status", rd, 32'h00000120);
      bus(1'b0, REG_EVENTS, 32'h0, rd);
      ck("events", rd, 32'h0000000F);
      bus(1'b1, REG_EVENTS, 32'h0000000F, rd);
      bus(1'b0, REG_EVENTS, 32'h0, rd);
      ck("ev_clr", rd, 32'h00000000);
      bus(1'b0, 8'h0C, 32'h0, rd);
      ck("unmapped", rd, 32'h00000000);
      bus(1'b0, REG_CTRL, 32'h0, rd);
      ck("ctrl", rd, CTRL_RESET);
      $display("bus done");
   endtask

   task automatic t_rst();
      ed(1);
      temp_c <= 8'h96;
      ed(4);
      temp_c <= 8'h64;
      ed(4);
      #1;
      ck("ot_set", overtemp_fault_r, 1'b1);
      ed(1);
      rst <= 1'b1;
      ed(3);
      rst <= 1'b0;
      ed(5);
      #1;
      ck("ot_cold", overtemp_fault_r, 1'b0);
      $display("reset done");
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      ed(3);
      rst <= 1'b0;
      #1;
      ck("reset", snap, 12'hE38);
      t_power();
      t_dip();
      t_brown();
      t_faults();
      t_tpin();
      t_bus();
      t_rst();
      results();
   end

   // the tests need roughly six thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      results();
   end
endmodule
